// File: irqpr_ctrl.sv
`timescale 1ns/1ps
module irqpr_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [irqpr_pkg::BUS_DW-1:0] wb_dat_w,
  output logic [irqpr_pkg::BUS_DW-1:0] wb_dat_r,
  output logic wb_ack,
  // Raw requests of the three sources
  input wire logic serial_event_req,
  input wire logic serial_fault_req,
  input wire logic timer_three_req,
  // Priority fields toward the arbitration logic
  output logic [irqpr_pkg::FIELD_W-1:0] serial_event_priority,
  output logic [irqpr_pkg::FIELD_W-1:0] serial_fault_priority,
  output logic [irqpr_pkg::FIELD_W-1:0] timer_three_priority,
  // Winning request toward the processor
  output logic irq_req,
  output logic [irqpr_pkg::FIELD_W-1:0] irq_level,
  output logic [irqpr_pkg::IDX_W-1:0] irq_source
);

  localparam int FW = irqpr_pkg::FIELD_W;
  localparam int NS = irqpr_pkg::NUM_SRC;
  localparam int IW = irqpr_pkg::IDX_W;
  localparam int DW = irqpr_pkg::BUS_DW;
  localparam int RW = irqpr_pkg::REG_W;

  // Bus phase
  irqpr_pkg::irqpr_bus_state_t bus_state_reg;
  irqpr_pkg::irqpr_bus_state_t bus_state_next;

  // Bus decode
  logic bus_req;
  logic hit_prio;
  logic hit_stat;
  logic [RW-1:0] wr_mask;

  // Priority control word, only implemented bits ever hold ones
  logic [RW-1:0] prio_reg;
  logic [RW-1:0] prio_next;

  // Read data, captured when the request is first seen
  logic [DW-1:0] dat_r_reg;
  logic [DW-1:0] dat_r_next;

  // Raw requests and their registered copy
  logic [NS-1:0] req_raw;
  logic [NS-1:0] req_sync_reg;
  logic [NS-1:0] req_sync_next;

  // Per-source view, index 0 is the timer
  logic [FW-1:0] src_field [NS];
  logic [NS-1:0] src_active;
  logic [FW-1:0] src_level [NS];

  // Arbitration result before registering
  logic win_any;
  logic [FW-1:0] win_level;
  logic [IW-1:0] win_index;

  // Registered winner toward the processor
  logic irq_req_reg;
  logic irq_req_next;
  logic [FW-1:0] irq_level_reg;
  logic [FW-1:0] irq_level_next;
  logic [IW-1:0] irq_source_reg;
  logic [IW-1:0] irq_source_next;

  // Status word seen on the second bus offset
  logic [RW-1:0] status_word;

  // Refuse geometries the decode and packing cannot serve
  if (ADDR_W < 3 || ADDR_W > DW) begin : g_bad_addr
    $error("irqpr_ctrl: ADDR_W must cover both offsets");
  end
  if (NS != 3 || RW != 16) begin : g_bad_geom
    $error("irqpr_ctrl: package geometry not supported");
  end

  // Gather the three raw requests by source index
  always_comb begin
    req_raw = '0;
    req_raw[irqpr_pkg::SRC_TIMER] = timer_three_req;
    req_raw[irqpr_pkg::SRC_FAULT] = serial_fault_req;
    req_raw[irqpr_pkg::SRC_EVENT] = serial_event_req;
  end

  // Request strobes and word select
  assign bus_req = wb_cyc && wb_stb;
  assign hit_prio = (wb_adr == ADDR_W'(irqpr_pkg::PRIO_OFFSET));
  assign hit_stat = (wb_adr == ADDR_W'(irqpr_pkg::STAT_OFFSET));

  // Ack one cycle after the request; dropped when the master lets go
  assign wb_ack = (bus_state_reg == irqpr_pkg::BUS_ACK) && bus_req;

  // Bus phase: one wait state, then ack for a single cycle
  always_comb begin
    bus_state_next = bus_state_reg;
    unique case (bus_state_reg)
      irqpr_pkg::BUS_IDLE: begin
        if (bus_req) begin
          bus_state_next = irqpr_pkg::BUS_ACK;
        end
      end
      irqpr_pkg::BUS_ACK: begin
        // Always back to idle, so ack never stands two cycles
        bus_state_next = irqpr_pkg::BUS_IDLE;
      end
    endcase
  end

  // Bus phase register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_state_reg <= irqpr_pkg::BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Byte lanes that may change; unused bits never take a write
  always_comb begin
    wr_mask = '0;
    for (int b = 0; b < RW / 8; b++) begin
      if (wb_sel[b]) begin
        wr_mask[b*8 +: 8] = 8'hFF;
      end
    end
    wr_mask = wr_mask & irqpr_pkg::PRIO_IMPL_MASK;
  end

  // Control word update, taken at the edge where ack is high
  always_comb begin
    prio_next = prio_reg;
    if (wb_ack && wb_we && hit_prio) begin
      prio_next = (prio_reg & ~wr_mask) |
                  (wb_dat_w[RW-1:0] & wr_mask);
    end
  end

  // Control word register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_reg <= irqpr_pkg::PRIO_RESET;
    end else begin
      prio_reg <= prio_next;
    end
  end

  // Status packing: raw, qualified, winner level and source
  always_comb begin
    status_word = '0;
    status_word[irqpr_pkg::STAT_RAW_LSB +: NS] = req_sync_reg;
    status_word[irqpr_pkg::STAT_ACT_LSB +: NS] = src_active;
    status_word[irqpr_pkg::STAT_LVL_LSB +: FW] = irq_level_reg;
    status_word[irqpr_pkg::STAT_SRC_LSB +: IW] = irq_source_reg;
    status_word[irqpr_pkg::STAT_ANY_BIT] = irq_req_reg;
  end

  // Read data captured on the request's first cycle
  // Held through the ack cycle so the master sees a steady word
  always_comb begin
    dat_r_next = dat_r_reg;
    if ((bus_state_reg == irqpr_pkg::BUS_IDLE) && bus_req) begin
      dat_r_next = '0;
      if (hit_prio) begin
        dat_r_next[RW-1:0] = prio_reg & irqpr_pkg::PRIO_IMPL_MASK;
      end else if (hit_stat) begin
        dat_r_next[RW-1:0] = status_word;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dat_r_reg <= '0;
    end else begin
      dat_r_reg <= dat_r_next;
    end
  end

  assign wb_dat_r = dat_r_reg;

  // Requests are synchronous already; one stage keeps paths short
  always_comb begin
    req_sync_next = req_raw;
  end

  // Request register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_sync_reg <= '0;
    end else begin
      req_sync_reg <= req_sync_next;
    end
  end

  // One qualifier per source, field picked from its own position
  for (genvar i = 0; i < NS; i++) begin : g_src
    // Event field at 10:8, fault 6:4, timer 2:0
    assign src_field[i] = prio_reg[irqpr_pkg::SRC_LSB[i] +: FW];

    irqpr_source #(
      .FIELD_W(FW)
    ) u_source (
      .field_val(src_field[i]),
      .src_req(req_sync_reg[i]),
      .req_active(src_active[i]),
      .req_level(src_level[i])
    );
  end

  // Highest level wins; a tie goes to the lower source index
  // A zero field never reaches here, as the source is inactive
  always_comb begin
    win_any = 1'b0;
    win_level = irqpr_pkg::LEVEL_OFF;
    win_index = irqpr_pkg::SRC_TIMER;
    for (int i = 0; i < NS; i++) begin
      if (src_active[i] && (src_level[i] > win_level)) begin
        win_any = 1'b1;
        win_level = src_level[i];
        win_index = IW'(i);
      end
    end
  end

  // Winner next values
  always_comb begin
    irq_req_next = win_any;
    irq_level_next = win_level;
    irq_source_next = win_index;
  end

  // Winner registers; costs a cycle but gives glitch-free outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req_reg <= 1'b0;
      irq_level_reg <= irqpr_pkg::LEVEL_OFF;
      irq_source_reg <= irqpr_pkg::SRC_TIMER;
    end else begin
      irq_req_reg <= irq_req_next;
      irq_level_reg <= irq_level_next;
      irq_source_reg <= irq_source_next;
    end
  end

  // Fields toward the arbitration logic
  assign serial_event_priority = src_field[irqpr_pkg::SRC_EVENT];
  assign serial_fault_priority = src_field[irqpr_pkg::SRC_FAULT];
  assign timer_three_priority = src_field[irqpr_pkg::SRC_TIMER];

  // Winner toward the processor
  assign irq_req = irq_req_reg;
  assign irq_level = irq_level_reg;
  assign irq_source = irq_source_reg;

  // Notes for users of this block:
  // The status word is read only; writes to it are acked and dropped.
  // Offsets outside the two words read zero and drop writes too.
  // A read of the control word shows the value before a write
  // that is acked in the same cycle; writes never overlap reads
  // on a classic single-cycle bus, so this cannot be observed.
  // The winner output trails a field change by one clock, and a
  // request change by two, because both pass through registers.
  // Every unimplemented bit is forced to zero twice over: once by
  // the write mask and again on read, so a bad reset value
  // constant could not leak into software's view.

endmodule

// File: irqpr_pkg.sv
package irqpr_pkg;

  // Bus and register geometry
  localparam int BUS_DW = 32;
  localparam int REG_W = 16;
  localparam int FIELD_W = 3;
  localparam int NUM_SRC = 3;
  localparam int IDX_W = 2;

  // Byte offsets of the two words on the bus
  localparam logic [31:0] PRIO_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STAT_OFFSET = 32'h0000_0004;

  // Field positions in the priority word, index 0 is the timer
  localparam int TIMER_LSB = 0;
  localparam int FAULT_LSB = 4;
  localparam int EVENT_LSB = 8;
  localparam int SRC_LSB [NUM_SRC] = '{TIMER_LSB, FAULT_LSB, EVENT_LSB};

  // Source indices as reported in status
  localparam logic [IDX_W-1:0] SRC_TIMER = 2'h0;
  localparam logic [IDX_W-1:0] SRC_FAULT = 2'h1;
  localparam logic [IDX_W-1:0] SRC_EVENT = 2'h2;

  // Priority encoding
  localparam logic [FIELD_W-1:0] LEVEL_OFF = 3'h0;
  localparam logic [FIELD_W-1:0] LEVEL_MIN = 3'h1;
  localparam logic [FIELD_W-1:0] LEVEL_MAX = 3'h7;

  // Reset value of each field and of the whole word
  localparam logic [FIELD_W-1:0] FIELD_RESET = 3'h4;
  localparam logic [REG_W-1:0] PRIO_RESET = 16'h0444;

  // Bits that exist; all others read zero and drop writes
  localparam logic [REG_W-1:0] PRIO_IMPL_MASK = 16'h0777;

  // Status word layout
  localparam int STAT_RAW_LSB = 0;
  localparam int STAT_ACT_LSB = 4;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_SRC_LSB = 12;
  localparam int STAT_ANY_BIT = 15;

  // Bus slave phases
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } irqpr_bus_state_t;

endpackage

// File: irqpr_source.sv
`timescale 1ns/1ps
module irqpr_source #(
  parameter int FIELD_W = 3
) (
  // Priority field from the control word
  input wire logic [FIELD_W-1:0] field_val,
  // Sampled request of the source
  input wire logic src_req,
  // Qualified request and its level
  output logic req_active,
  output logic [FIELD_W-1:0] req_level
);

  // Zero field blocks the source outright
  always_comb begin
    req_active = src_req && (field_val != irqpr_pkg::LEVEL_OFF);
    req_level = irqpr_pkg::LEVEL_OFF;
    if (req_active) begin
      req_level = field_val;
    end
  end

  initial begin
    if (FIELD_W != irqpr_pkg::FIELD_W) begin
      $error("irqpr_source: FIELD_W must match the package");
    end
  end

endmodule

// File: irqpr_sva.sv
`timescale 1ns/1ps
module irqpr_sva(
  // Bus side and outputs
  input wire logic clk,rst,wb_we,wb_ack,irq_req,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_w,wb_dat_r,
  input wire logic [2:0] serial_event_priority,serial_fault_priority,
  input wire logic [2:0] timer_three_priority,irq_level
);
  // Priority word write taken
  wire wr=wb_ack&wb_we&(wb_adr==8'h00);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_EV: assert property(wr|=>
    serial_event_priority==$past(wb_dat_w[10:8])) else $error("ev");
  AST_FA: assert property(wr|=>
    serial_fault_priority==$past(wb_dat_w[6:4])) else $error("fa");
  AST_TM: assert property(wr|=>
    timer_three_priority==$past(wb_dat_w[2:0])) else $error("tm");
  AST_RSV: assert property(wb_ack&!wb_we&(wb_adr==8'h00)
    |->(wb_dat_r[15:0]&16'hF888)==16'h0000) else $error("rsv");
  AST_OFF: assert property(({serial_event_priority,
    serial_fault_priority,timer_three_priority}==9'h000)[*3]
    |->!irq_req) else $error("off");
  AST_LVL: assert property(irq_req|->irq_level!=3'h0)
    else $error("lvl");
endmodule
bind irqpr_ctrl irqpr_sva u_sva(.*);

// File: tb_irqpr_ctrl.sv
`timescale 1ns/1ps
module tb_irqpr_ctrl;
  logic clk=0,rst=1,cyc=0,we=0,ack,rq;
  logic [2:0] req=3'h0,ep,fp,tp,lv;
  logic [1:0] src;
  logic [31:0] dw=32'h0,dr,rd;
  int num_errors=0,checked=0;
  `define CK(a,b) checked++; if((a)!==(b)) begin num_errors++; \
    $display("unexpected %0t %h %h",$time,a,b); end
  always #5 clk=~clk;
  irqpr_ctrl dut(.clk(clk),.rst(rst),.wb_cyc(cyc),.wb_stb(cyc),
    .wb_we(we),.wb_adr(8'h00),.wb_sel(4'hF),.wb_dat_w(dw),
    .wb_dat_r(dr),.wb_ack(ack),.serial_event_req(req[2]),
    .serial_fault_req(req[1]),.timer_three_req(req[0]),
    .serial_event_priority(ep),.serial_fault_priority(fp),
    .timer_three_priority(tp),.irq_req(rq),.irq_level(lv),
    .irq_source(src));
  // Single cycle; request held until ack is seen
  task bus(input logic w,input logic [31:0] d);
    cyc<=1; we<=w; dw<=d;
    do @(posedge clk); while(ack!==1'b1);
    rd=dr; cyc<=0; @(posedge clk);
  endtask
  // Every level in all fields, spare bits written high
  task t_fields;
    for(int v=0;v<8;v++) begin
      bus(1,32'hFFFFF888|(v*32'h111)); bus(0,32'h0);
      `CK(rd[15:0],16'(v*16'h111))
      `CK({ep,fp,tp},9'(v*9'o111))
    end
  endtask
  // Level seven wins, one still requests, zero never does
  task t_irq;
    req<=3'h7; bus(1,32'h710); repeat(3) @(posedge clk);
    `CK({rq,lv},4'hF)
    `CK(src,2'h2)
    bus(1,32'h10); repeat(3) @(posedge clk);
    `CK({rq,lv},4'h9)
    `CK(src,2'h1)
    bus(1,32'h0); repeat(3) @(posedge clk);
    `CK(rq,1'b0)
  endtask
  task final_report;
    $display("errors %0d checks %0d",num_errors,checked);
    if(num_errors==0&&checked>0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat(3) @(posedge clk);
    rst<=0; @(posedge clk);
    t_fields; t_irq; final_report;
  end
  // Hang guard, far beyond the few dozen cycles used
  initial begin
    #50000 num_errors++;
    final_report;
  end
endmodule
